/* File: hw/echp_host_port.sv */
// Overview of operation
// - Reset low holds device in standby
// - Reset release runs init, loads defaults
// - Any channel interrupt outside standby/init pulls request low
// - Request releases once FIFO fully read
// - Chip select high: bus ignored
// - Access only with strobe and select low
// - Read/write pin sets bus direction
// - Acknowledge driven low on transfer done
// - Single 8-bit bidirectional data bus
`timescale 1ns/100ps
`default_nettype none

module echp_host_port
   import echp_pkg::*;
#(
   parameter int INIT_LEN = echp_pkg::INIT_CYCLES
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic                        device_reset_n,
   input  wire logic                        chip_select_n,
   input  wire logic                        data_strobe_n,
   input  wire logic                        read_not_write,
   input  wire logic [echp_pkg::ADDR_W-1:0] addr,
   input  wire logic [echp_pkg::DATA_W-1:0] data_in,
   output logic      [echp_pkg::DATA_W-1:0] data_out,
   output logic                             data_oe,
   output logic                             transfer_ack_out,
   output logic                             transfer_ack_oe,
   output logic                             interrupt_request_out,
   output logic                             interrupt_request_oe,
   input  wire logic                        irq_event,
   input  wire logic [echp_pkg::CHAN_W-1:0] irq_channel,
   output logic                             reg_wr_en,
   output logic                             reg_rd_en,
   output logic      [echp_pkg::ADDR_W-1:0] reg_addr,
   output logic      [echp_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic [echp_pkg::DATA_W-1:0] reg_rdata,
   output logic                             standby,
   output logic                             init_busy
);
   import echp_pkg::*;

   localparam logic [INIT_W-1:0] INIT_LOAD = INIT_W'(INIT_LEN - 1);
   localparam logic [INIT_W-1:0] INIT_ONE  = INIT_W'(1);

   echp_state_e       state;
   echp_state_e       next_state;
   logic [INIT_W-1:0] init_count;
   logic              access_req;
   logic              irq_addr_hit;
   logic              fifo_pop;
   logic              fifo_clear;
   logic [CHAN_W-1:0] fifo_head;
   logic              fifo_empty;
   logic              fifo_full;
   logic              access_is_read;
   logic [DATA_W-1:0] irq_word;

   // Port is open only with both strobes low
   // select gates access
   assign access_req   = !chip_select_n && !data_strobe_n;
   assign irq_addr_hit = (addr == IRQ_FIFO_ADDR);
   assign fifo_pop     = (state == ST_IDLE) && access_req && read_not_write && irq_addr_hit;
   assign fifo_clear   = (state == ST_STANDBY) || (state == ST_INIT);

   // FIFO read word carries a valid flag so software sees the end
   always_comb begin
      irq_word = IRQ_EMPTY_WORD;
      if (!fifo_empty) begin
         irq_word[CHAN_W-1:0]    = fifo_head;
         irq_word[IRQ_VALID_BIT] = 1'b1;
      end
   end

   // Channel interrupt queue
   echp_irq_fifo #(
      .WIDTH (CHAN_W),
      .DEPTH (FIFO_DEPTH)
   ) u_irq_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clear     (fifo_clear),
      .push      (irq_event && !fifo_clear),
      .push_data (irq_channel),
      .pop       (fifo_pop),
      .head      (fifo_head),
      .empty     (fifo_empty),
      .full      (fifo_full)
   );

   // Sequencer next state; device reset overrides everything
   always_comb begin
      next_state = state;
      unique case (state)
         ST_STANDBY: begin
            if (device_reset_n) begin
               next_state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (init_count == '0) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (access_req) begin
               next_state = (read_not_write && !irq_addr_hit) ? ST_READ : ST_ACK;
            end
         end
         ST_READ: begin
            next_state = ST_ACK;
         end
         ST_ACK: begin
            if (!access_req) begin
               next_state = ST_IDLE;
            end
         end
      endcase
      if (!device_reset_n) begin
         next_state = ST_STANDBY;
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_STANDBY;
      end else begin
         state <= next_state;
      end
   end

   // Init length counter, reloaded every standby cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_count <= INIT_LOAD;
      end else if (state == ST_STANDBY) begin
         init_count <= INIT_LOAD;
      end else if ((state == ST_INIT) && (init_count != '0)) begin
         init_count <= init_count - INIT_ONE;
      end
   end

   // Mode flags for the core: standby gates its clocks, init loads defaults
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         standby   <= 1'b1;
         init_busy <= 1'b0;
      end else begin
         standby   <= (next_state == ST_STANDBY);
         init_busy <= (next_state == ST_INIT);
      end
   end

   // Register strobes toward the core, one cycle each
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_wr_en      <= 1'b0;
         reg_rd_en      <= 1'b0;
         reg_addr       <= '0;
         reg_wdata      <= '0;
         access_is_read <= 1'b0;
      end else begin
         reg_wr_en <= 1'b0;
         reg_rd_en <= 1'b0;
         if ((state == ST_IDLE) && access_req && device_reset_n) begin
            access_is_read <= read_not_write;
            reg_addr       <= addr;
            reg_wdata      <= data_in;
            reg_wr_en      <= !read_not_write;
            reg_rd_en      <= read_not_write && !irq_addr_hit;
         end
      end
   end

   // Read data and bus drive; enable only while the read is acknowledged
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= '0;
         data_oe  <= 1'b0;
      end else begin
         data_oe <= 1'b0;
         if ((state == ST_IDLE) && (next_state == ST_ACK) && read_not_write) begin
            data_out <= irq_word;
            data_oe  <= 1'b1;
         end else if ((state == ST_READ) && (next_state == ST_ACK)) begin
            data_out <= reg_rdata;
            data_oe  <= 1'b1;
         end else if ((state == ST_ACK) && (next_state == ST_ACK)) begin
            data_oe <= access_is_read;
         end
      end
   end

   // Open-drain acknowledge: output is always low, enable pulls the wire
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         transfer_ack_out <= 1'b0;
         transfer_ack_oe  <= 1'b0;
      end else begin
         transfer_ack_oe <= (next_state == ST_ACK);
      end
   end

   // Open-drain interrupt request follows FIFO occupancy
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_request_out <= 1'b0;
         interrupt_request_oe  <= 1'b0;
      end else begin
         interrupt_request_oe <= !fifo_empty;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_standby_hold: assert property (!device_reset_n |=> state == ST_STANDBY && standby)
      else $error("device not in standby under reset");
   chk_init_start: assert property (state == ST_STANDBY && device_reset_n |=> init_busy)
      else $error("init did not start after reset release");
   chk_init_end: assert property (state == ST_INIT && init_count == '0 && device_reset_n |=> state == ST_IDLE)
      else $error("init did not finish on count zero");
   chk_irq_assert: assert property (irq_event && state == ST_IDLE && device_reset_n |-> ##2 interrupt_request_oe)
      else $error("interrupt request not raised after event");
   chk_irq_release: assert property (fifo_empty |=> !interrupt_request_oe)
      else $error("interrupt request held with empty fifo");
   chk_select_ignore: assert property (chip_select_n && state == ST_IDLE |=> !reg_wr_en && !reg_rd_en)
      else $error("access taken with chip select high");
   chk_strobe_pair: assert property (reg_wr_en || reg_rd_en |-> $past(access_req))
      else $error("access without both strobes low");
   chk_read_dir: assert property (data_oe |-> access_is_read)
      else $error("data bus driven during a write");
   chk_ack_write: assert property (reg_wr_en |-> transfer_ack_oe)
      else $error("write not acknowledged");
   chk_bus_float: assert property (data_oe |-> state == ST_ACK)
      else $error("data bus driven outside acknowledge");
   chk_ack_release: assert property (transfer_ack_oe && !access_req |=> !transfer_ack_oe)
      else $error("acknowledge held after strobes released");

   cov_write: cover property (reg_wr_en ##2 !transfer_ack_oe);
   cov_read: cover property (reg_rd_en ##1 data_oe);
   cov_irq_drain: cover property (interrupt_request_oe ##[1:50] !interrupt_request_oe);
   cov_fifo_full: cover property (fifo_full);

endmodule // echp_host_port

`default_nettype wire

/* File: hw/echp_pkg.sv */
package echp_pkg;

   // Port widths
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;

   // Channel count and interrupt FIFO shape
   localparam int CHAN_W     = 5;
   localparam int FIFO_DEPTH = 32;

   // Address of the interrupt FIFO read port
   localparam logic [ADDR_W-1:0] IRQ_FIFO_ADDR = 11'h7FF;

   // Interrupt FIFO read word: valid flag on top, channel in the low bits
   localparam int IRQ_VALID_BIT = 7;
   localparam logic [DATA_W-1:0] IRQ_EMPTY_WORD = 8'h00;

   // Length of the initialization sequence after reset release
   localparam int INIT_CYCLES = 16;
   localparam int INIT_W      = 5;

   // Port sequencer states
   typedef enum logic [4:0] {
      ST_STANDBY = 5'h01,
      ST_INIT    = 5'h02,
      ST_IDLE    = 5'h04,
      ST_READ    = 5'h08,
      ST_ACK     = 5'h10
   } echp_state_e;

endpackage : echp_pkg

/* File: hw/echp_irq_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module echp_irq_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             clear,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic                  empty,
   output logic                  full
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W:0] ONE_CNT   = (PTR_W+1)'(1);
   localparam logic [PTR_W-1:0] ONE_PTR = PTR_W'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   logic             do_push;
   logic             do_pop;

   // A push into a full FIFO is dropped rather than overwriting old entries
   assign do_push = push && (count != DEPTH_CNT);
   assign do_pop  = pop && (count != '0);
   assign head    = mem[rd_ptr];
   assign empty   = (count == '0);
   assign full    = (count == DEPTH_CNT);

   // Storage array, no reset needed
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   // Pointers and fill level; push and pop together keep the level
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + ONE_PTR;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + ONE_PTR;
         end
         if (do_push && !do_pop) begin
            count <= count + ONE_CNT;
         end else if (do_pop && !do_push) begin
            count <= count - ONE_CNT;
         end
      end
   end

endmodule // echp_irq_fifo

`default_nettype wire

/* File: sim/echp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Host processor on the far side of the parallel port
module echp_host_model (
   input  wire logic                        sys_clk,
   output logic                             chip_select_n,
   output logic                             data_strobe_n,
   output logic                             read_not_write,
   output logic      [echp_pkg::ADDR_W-1:0] addr,
   output logic      [echp_pkg::DATA_W-1:0] data_in,
   input  wire logic [echp_pkg::DATA_W-1:0] data_out,
   input  wire logic                        data_oe,
   input  wire logic                        transfer_ack_oe
);
   import echp_pkg::*;

   logic [DATA_W-1:0] host_d = 8'hA5;

   assign data_in = data_oe ? data_out : host_d;

   // Undriven bus keeps changing, never holds a stale byte
   always @(negedge sys_clk) begin
      if (read_not_write) host_d = ~host_d;
   end

   initial begin
      chip_select_n  = 1'b1;
      data_strobe_n  = 1'b1;
      read_not_write = 1'b1;
      addr           = '0;
   end

   // One access; ok stays low if no acknowledge within the bound
   task automatic xfer(input logic cs_n, input logic rnw, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = '0;
      @(negedge sys_clk);
      addr = a;
      read_not_write = rnw;
      if (!rnw) host_d = wd;
      chip_select_n = cs_n;
      data_strobe_n = 1'b0;
      for (n = 0; n < 24 && !ok; n++) begin
         @(posedge sys_clk);
         if (transfer_ack_oe === 1'b1) begin
            ok = 1'b1;
            // Bus level, so an undriven read shows noise
            rd = data_in;
         end
      end
      @(negedge sys_clk);
      chip_select_n  = 1'b1;
      data_strobe_n  = 1'b1;
      read_not_write = 1'b1;
      addr           = ~a;
   endtask
endmodule // echp_host_model

`default_nettype wire

/* File: sim/echo_canceller_host_port_test.sv */
`timescale 1ns/100ps
`default_nettype none

module echo_canceller_host_port_test;
   import echp_pkg::*;

   localparam int INIT_N = 4;

   logic              sys_clk = 1'b0, rst_n = 1'b0, device_reset_n = 1'b0, irq_event = 1'b0;
   logic              cs_n, ds_n, rnw, data_oe, ack_out, ack_oe, irq_out, irq_oe;
   logic              wr_en, rd_en, standby, init_busy, ok;
   logic [ADDR_W-1:0] addr, reg_addr, a, last_wa;
   logic [DATA_W-1:0] data_in, data_out, reg_wdata, reg_rdata, rd, last_wd;
   logic [CHAN_W-1:0] irq_channel;
   logic [31:0]       lfsr = 32'h3529C918;
   int                n_errors = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0, exp_rd = 0, n, w0;

   echp_host_port #(.INIT_LEN(INIT_N)) echp_host_port_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .device_reset_n(device_reset_n), .chip_select_n(cs_n),
      .data_strobe_n(ds_n), .read_not_write(rnw), .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .transfer_ack_out(ack_out), .transfer_ack_oe(ack_oe), .interrupt_request_out(irq_out),
      .interrupt_request_oe(irq_oe), .irq_event(irq_event), .irq_channel(irq_channel), .reg_wr_en(wr_en),
      .reg_rd_en(rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .standby(standby), .init_busy(init_busy));

   echp_host_model echp_host_model_inst (
      .sys_clk(sys_clk), .chip_select_n(cs_n), .data_strobe_n(ds_n), .read_not_write(rnw), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .transfer_ack_oe(ack_oe));

   // Master clock from the host side
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Register core stand-in: data tied to the address
   function automatic logic [DATA_W-1:0] core_data(input logic [ADDR_W-1:0] x);
      return x[7:0] ^ {x[10:8], 5'h0A};
   endfunction

   always @(negedge sys_clk) begin
      reg_rdata <= core_data(reg_addr);
   end

   // Record every register strobe toward the core
   always @(posedge sys_clk) begin
      if (rd_en === 1'b1) begin
         rd_cnt++;
      end
      if (wr_en === 1'b1) begin
         wr_cnt++;
         last_wa = reg_addr;
         last_wd = reg_wdata;
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Access, then confirm the port lets go of both pins
   task automatic acc(input logic c, input logic r, input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] wd,
                      input logic exp_ok);
      echp_host_model_inst.xfer(c, r, x, wd, rd, ok);
      chk("ack", ok, exp_ok);
      repeat (2) @(negedge sys_clk);
      chk("ack_rel", ack_oe, 1'b0);
      chk("bus_rel", data_oe, 1'b0);
      chk("ack_lvl", ack_out, 1'b0);
      chk("irq_lvl", irq_out, 1'b0);
      if (ok !== exp_ok) report_and_stop();
   endtask

   task automatic wait_init;
      n = 0;
      for (int i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         if (init_busy === 1'b1) n++;
      end
   endtask

   task automatic irq_pulse(input logic [CHAN_W-1:0] ch);
      @(negedge sys_clk);
      irq_channel = ch;
      irq_event   = 1'b1;
      @(negedge sys_clk);
      irq_event   = 1'b0;
   endtask

   initial begin
      irq_channel = '0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      chk("standby", standby, 1'b1);
      acc(1'b0, 1'b0, 11'h012, 8'h3C, 1'b0);
      chk("wr_standby", wr_cnt, 0);
      device_reset_n = 1'b1;
      wait_init();
      chk("init_len", n, INIT_N);
      chk("standby_off", standby, 1'b0);
      // Random reads and writes, edge addresses first
      for (int i = 0; i < 14; i++) begin
         lfsr = next_rand(lfsr);
         a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FE : lfsr[10:0] & 11'h7FE;
         acc(1'b0, lfsr[20], a, lfsr[31:24], 1'b1);
         if (lfsr[20]) begin
            exp_rd++;
            chk("rdata", rd, core_data(a));
         end else begin
            chk("waddr", last_wa, a);
            chk("wdata", last_wd, lfsr[31:24]);
         end
      end
      // One core strobe per access, by direction
      chk("rd_strobes", rd_cnt, exp_rd);
      chk("wr_strobes", wr_cnt, 14 - exp_rd);
      w0 = wr_cnt;
      acc(1'b1, 1'b0, 11'h055, 8'hAA, 1'b0);
      chk("wr_desel", wr_cnt, w0);
      irq_pulse(5'd3);
      irq_pulse(5'd17);
      repeat (3) @(negedge sys_clk);
      chk("irq_on", irq_oe, 1'b1);
      acc(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, 1'b1);
      chk("fifo_a", rd, 8'h83);
      chk("irq_hold", irq_oe, 1'b1);
      acc(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, 1'b1);
      chk("fifo_b", rd, 8'h91);
      chk("irq_off", irq_oe, 1'b0);
      acc(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, 1'b1);
      chk("fifo_empty", rd, IRQ_EMPTY_WORD);
      irq_pulse(5'd9);
      repeat (3) @(negedge sys_clk);
      device_reset_n = 1'b0;
      // FIFO clears one edge after standby, request one edge later
      repeat (3) @(negedge sys_clk);
      chk("standby_again", standby, 1'b1);
      chk("irq_cleared", irq_oe, 1'b0);
      device_reset_n = 1'b1;
      wait_init();
      chk("init_again", n, INIT_N);
      acc(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, 1'b1);
      chk("fifo_reset", rd, IRQ_EMPTY_WORD);
      // Interrupt queue reads never reach the core
      chk("rd_fifo", rd_cnt, exp_rd);
      report_and_stop();
   end
endmodule // echo_canceller_host_port_test

`default_nettype wire
